//--- core/io_port_cycle.sv
/*
 * One device port access: drives address, strobes and data for a fixed
 * number of cycles and returns read data.  Assumes a synchronous device
 * bus on the same clock whose read data is stable during the strobe.
 */
`timescale 1ns/1ps
module io_port_cycle #(
    parameter int STROBE_CYC = irq_init_pkg::IO_STROBE_CYC
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Request side.
    input  wire logic       start,
    input  wire logic       is_read,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic            done,
    output logic [7:0]      rdata,
    // Device bus.
    output logic [7:0]      io_addr,
    output logic            io_wr_b,
    output logic            io_rd_b,
    output logic [7:0]      io_dout,
    output logic            io_doe,
    input  wire logic [7:0] io_din
);
    typedef struct packed {
        logic       busy;
        logic [3:0] cnt;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wd;
        logic [7:0] rd_data;
        logic       done;
    } cyc_s;
    cyc_s st_ff;
    cyc_s nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // Strobe timing; read data is caught on the last strobe cycle.
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (!st_ff.busy && start) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt  = 4'(STROBE_CYC - 1);
            nxt_st.rd   = is_read;
            nxt_st.addr = addr;
            nxt_st.wd   = wdata;
        end else if (st_ff.busy) begin
            if (st_ff.cnt == 4'h0) begin
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
                if (st_ff.rd) begin
                    nxt_st.rd_data = io_din;
                end
            end else begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state register.
    assign done    = st_ff.done;
    assign rdata   = st_ff.rd_data;
    assign io_addr = st_ff.addr;
    assign io_wr_b = !(st_ff.busy && !st_ff.rd);
    assign io_rd_b = !(st_ff.busy && st_ff.rd);
    assign io_dout = st_ff.wd;
    assign io_doe  = st_ff.busy && !st_ff.rd;
endmodule : io_port_cycle

//--- core/irq_init_host.sv
/*
 * Host-side sequencer that initialises an eight-level priority interrupt
 * unit through its I/O ports and then issues operation words on request.
 * Assumes an APB master on clk and a device bus on the same clock.
 *
 * Software fills CONFIG and CASCADE first, then writes CTRL with the start
 * bit; the role bit in that same write picks master or slave words.  While
 * the sequence runs, every register write is ignored, so a configuration
 * cannot change underneath a half-written initialisation.  Operation words
 * are refused until the latest sequence has finished; afterwards they may be
 * issued whenever the sequencer is idle and do not disturb the finished flag.
 *
 * A limitation worth knowing: the interrupt gate output only reflects this
 * block's own progress.  If several units are chained, software must keep
 * the processor's interrupts off until the last unit has been programmed.
 */
`timescale 1ns/1ps
module irq_init_host (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Device bus.
    output logic [7:0]       io_addr,
    output logic             io_wr_b,
    output logic             io_rd_b,
    output logic [7:0]       io_dout,
    output logic             io_doe,
    input  wire logic [7:0]  io_din,
    // Processor interrupt gate.
    output logic             cpu_irq_enable
);
    typedef enum logic [2:0] {
        S_IDLE, S_FIRST, S_VECTOR, S_CASCADE, S_OPTIONS, S_OPER, S_WAIT
    } seq_e;

    typedef struct packed {
        seq_e       state;
        seq_e       after;
        logic [7:0] config_r;
        logic [7:0] cascade_r;
        logic       is_slave;
        logic       inited;
        logic       op_pend;
        logic [9:0] op_word;
        logic [7:0] rd_byte;
        logic       start;
        logic       is_read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_s;
    host_s st_ff;
    host_s nxt_st;

    logic       cyc_done;
    logic [7:0] cyc_rdata;
    logic       wr_acc;
    logic       busy;
    logic [7:0] first_word;
    logic [7:0] opt_word;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; every access completes without wait states.
    assign wr_acc  = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign busy    = (st_ff.state != S_IDLE);
    assign pslverr = psel && penable && !(paddr inside {irq_init_pkg::REG_CTRL,
                     irq_init_pkg::REG_CONFIG, irq_init_pkg::REG_CASCADE,
                     irq_init_pkg::REG_STATUS, irq_init_pkg::REG_OPWORD,
                     irq_init_pkg::REG_RDATA});

    // Read mux over own registers.
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            irq_init_pkg::REG_CONFIG:  prdata = {24'h0, st_ff.config_r};
            irq_init_pkg::REG_CASCADE: prdata = {24'h0, st_ff.cascade_r};
            irq_init_pkg::REG_STATUS:  prdata = {29'h0, st_ff.is_slave,
                                                 st_ff.inited, busy};
            irq_init_pkg::REG_RDATA:   prdata = {24'h0, st_ff.rd_byte};
            default:                   prdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Build the first and options words from the configuration register.
    // config bits: 0 single, 1 edge, 2 auto clear, 3 special nesting, 7:3 vector base.
    always_comb begin
        first_word = 8'h00;
        first_word[irq_init_pkg::FW_ID0_BIT] = 1'b1;
        first_word[irq_init_pkg::FW_ID4_BIT] = 1'b1;
        first_word[irq_init_pkg::FW_SINGLE_BIT] =
            st_ff.config_r[0] && !st_ff.is_slave;
        first_word[irq_init_pkg::FW_EDGE_BIT] = st_ff.config_r[1];
        opt_word = 8'h00;
        opt_word[irq_init_pkg::OPT_CPU_BIT]    = 1'b1;
        opt_word[irq_init_pkg::OPT_AUTO_BIT]   = st_ff.config_r[2];
        opt_word[irq_init_pkg::OPT_BUF_BIT]    = 1'b1;
        opt_word[irq_init_pkg::OPT_MASTER_BIT] = !st_ff.is_slave;
        opt_word[irq_init_pkg::OPT_NEST_BIT]   = st_ff.config_r[3];
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes and the initialisation sequencer.
    // Each word state raises a one-cycle start pulse and parks in S_WAIT;
    // the port engine's done pulse then moves on to the state kept in
    // 'after'.  Keeping one wait state avoids a copy of the handshake in
    // every word state.  The finished flag is only raised when the options
    // word completes, never after an operation word, which keeps the gate
    // for processor interrupts tied to a complete initialisation.
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.start = 1'b0;
        if (wr_acc && !busy) begin
            unique case (paddr)
                irq_init_pkg::REG_CONFIG:  nxt_st.config_r  = pwdata[7:0];
                irq_init_pkg::REG_CASCADE: nxt_st.cascade_r = pwdata[7:0];
                irq_init_pkg::REG_CTRL: begin
                    if (pwdata[irq_init_pkg::CTRL_START_BIT]) begin
                        nxt_st.is_slave = pwdata[irq_init_pkg::CTRL_ROLE_BIT];
                        nxt_st.inited   = 1'b0;
                        nxt_st.state    = S_FIRST;
                    end
                end
                irq_init_pkg::REG_OPWORD: begin
                    if (st_ff.inited) begin
                        nxt_st.op_word = pwdata[9:0];
                        nxt_st.state   = S_OPER;
                    end
                end
                default: begin
                end
            endcase
        end
        unique case (st_ff.state)
            S_IDLE: begin
            end
            S_FIRST: begin
                nxt_st.start   = 1'b1;
                nxt_st.is_read = 1'b0;
                nxt_st.addr    = irq_init_pkg::PORT_CMD;
                nxt_st.wdata   = first_word;
                nxt_st.after   = S_VECTOR;
                nxt_st.state   = S_WAIT;
            end
            S_VECTOR: begin
                nxt_st.start   = 1'b1;
                nxt_st.addr    = irq_init_pkg::PORT_DATA;
                // Base in bits 7:3; the device fills in the line number.
                nxt_st.wdata   = {st_ff.config_r[7:3], irq_init_pkg::VEC_LOW_ZERO};
                nxt_st.after   = (first_word[irq_init_pkg::FW_SINGLE_BIT]) ?
                                 S_OPTIONS : S_CASCADE;
                nxt_st.state   = S_WAIT;
            end
            S_CASCADE: begin
                nxt_st.start   = 1'b1;
                nxt_st.addr    = irq_init_pkg::PORT_DATA;
                // Master: presence map; slave: identity in bits 2:0.
                nxt_st.wdata   = st_ff.is_slave ? {5'h00, st_ff.cascade_r[2:0]}
                                                : st_ff.cascade_r;
                nxt_st.after   = S_OPTIONS;
                nxt_st.state   = S_WAIT;
            end
            S_OPTIONS: begin
                nxt_st.start   = 1'b1;
                nxt_st.addr    = irq_init_pkg::PORT_DATA;
                nxt_st.wdata   = opt_word;
                nxt_st.after   = S_IDLE;
                nxt_st.op_pend = 1'b0;
                nxt_st.state   = S_WAIT;
            end
            S_OPER: begin
                // Port select in bits 9:8 picks C0, C2, C4 or C6.
                nxt_st.start   = 1'b1;
                nxt_st.is_read = st_ff.op_word[irq_init_pkg::OPW_READ_BIT] ||
                                 st_ff.op_word[irq_init_pkg::OPW_PORT_HI];
                nxt_st.addr    = irq_init_pkg::PORT_CMD +
                                 {5'h00, st_ff.op_word[9:8], 1'b0};
                nxt_st.wdata   = st_ff.op_word[7:0];
                nxt_st.op_pend = 1'b1;
                nxt_st.after   = S_IDLE;
                nxt_st.state   = S_WAIT;
            end
            S_WAIT: begin
                if (cyc_done) begin
                    nxt_st.state = st_ff.after;
                    if (nxt_st.is_read) begin
                        nxt_st.rd_byte = cyc_rdata;
                    end
                    if (st_ff.after == S_IDLE && !st_ff.op_pend) begin
                        nxt_st.inited = 1'b1;
                    end
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff           <= '0;
            st_ff.state     <= S_IDLE;
            st_ff.after     <= S_IDLE;
            st_ff.config_r  <= irq_init_pkg::CONFIG_RST;
            st_ff.cascade_r <= irq_init_pkg::CASCADE_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Processor interrupts stay off until the sequence has finished.
    assign cpu_irq_enable = st_ff.inited && !busy;

    ////////////////////////////////////////////////////////////////////////
    // Device port access engine.
    io_port_cycle #(
        .STROBE_CYC (irq_init_pkg::IO_STROBE_CYC)
    ) u_cyc (
        .clk     (clk),
        .rst_b   (rst_b),
        .start   (st_ff.start),
        .is_read (st_ff.is_read),
        .addr    (st_ff.addr),
        .wdata   (st_ff.wdata),
        .done    (cyc_done),
        .rdata   (cyc_rdata),
        .io_addr (io_addr),
        .io_wr_b (io_wr_b),
        .io_rd_b (io_rd_b),
        .io_dout (io_dout),
        .io_doe  (io_doe),
        .io_din  (io_din)
    );
endmodule : irq_init_host

//--- inc/irq_init_pkg.sv
/*
 * Constants for the host-side sequencer that programs an eight-level priority
 * interrupt unit: device port offsets, word bit positions, own register map.
 * Assumes it is compiled before every design file that names it.
 */
package irq_init_pkg;
    // Device port offsets (byte addresses on the device's own I/O bus).
    localparam logic [7:0] PORT_CMD         = 8'hC0;
    localparam logic [7:0] PORT_DATA        = 8'hC2;
    localparam logic [7:0] PORT_STAT        = 8'hC4;
    localparam logic [7:0] PORT_MASK_RD     = 8'hC6;
    // First word bit positions.
    localparam int         FW_ID0_BIT       = 0;
    localparam int         FW_SINGLE_BIT    = 1;
    localparam int         FW_EDGE_BIT      = 3;
    localparam int         FW_ID4_BIT       = 4;
    // Options word bit positions and the vector word's low bits.
    localparam int         OPT_CPU_BIT      = 0;
    localparam int         OPT_AUTO_BIT     = 1;
    localparam int         OPT_MASTER_BIT   = 2;
    localparam int         OPT_BUF_BIT      = 3;
    localparam int         OPT_NEST_BIT     = 4;
    localparam logic [2:0] VEC_LOW_ZERO     = 3'h0;
    // Own APB register map (byte offsets).
    localparam logic [7:0] REG_CTRL         = 8'h00;
    localparam logic [7:0] REG_CONFIG       = 8'h04;
    localparam logic [7:0] REG_CASCADE      = 8'h08;
    localparam logic [7:0] REG_STATUS       = 8'h0C;
    localparam logic [7:0] REG_OPWORD       = 8'h10;
    localparam logic [7:0] REG_RDATA        = 8'h14;
    // Own register reset values.
    localparam logic [7:0] CONFIG_RST       = 8'h00;
    localparam logic [7:0] CASCADE_RST      = 8'h00;
    // Control register bits.
    localparam int         CTRL_START_BIT   = 0;
    localparam int         CTRL_ROLE_BIT    = 1;
    // Operation word register fields.
    localparam int         OPW_PORT_BIT     = 8;
    localparam int         OPW_READ_BIT     = 9;
    localparam int         OPW_PORT_HI      = 10;
    // Device bus timing in clock cycles.
    localparam int         IO_STROBE_CYC    = 2;
endpackage : irq_init_pkg

//--- test/irq_init_host_checker.sv
/* Port-level assertions for irq_init_host.
   Assumes it is bound to the design with every port connected by name. */
`timescale 1ns/1ps
module irq_init_host_checker (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst_b,
    // APB.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Device bus and gate.
    input wire logic [7:0]  io_addr,
    input wire logic        io_wr_b,
    input wire logic        io_rd_b,
    input wire logic [7:0]  io_dout,
    input wire logic        io_doe,
    input wire logic [7:0]  io_din,
    input wire logic        cpu_irq_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic vec_next_ff;
    ////////////////////////////////////////////////////////////////////////////
    // Marks that the next device write must carry the vector word.
    always_ff @(posedge clk) begin
        if (!rst_b) vec_next_ff <= 1'b0;
        else if ($fell(io_wr_b)) vec_next_ff <= io_addr == 8'hC0 && io_dout[4];
    end
    // Second strobe cycle, then release.
    sequence strobe_tail_s;
        !io_wr_b ##1 io_wr_b;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // Properties.
    chk_strobe_width: assert property ($fell(io_wr_b) |=> strobe_tail_s)
        else $error("write strobe width wrong");
    chk_held_word: assert property ($fell(io_wr_b) |=> $stable(io_addr) && $stable(io_dout))
        else $error("port or byte moved in strobe");
    chk_write_ports: assert property ($fell(io_wr_b) |-> io_addr inside {8'hC0, 8'hC2})
        else $error("write to wrong port");
    chk_first_ident: assert property (!io_wr_b && io_addr == 8'hC0 && io_dout[4] |-> io_dout[0])
        else $error("first word lacks bit 0");
    chk_vector_next: assert property (vec_next_ff && $fell(io_wr_b) |-> io_addr == 8'hC2 && io_dout[2:0] == 3'h0)
        else $error("vector word wrong");
    chk_doe_strobe: assert property (!io_wr_b |-> io_doe && io_rd_b)
        else $error("drive enable off in write");
    chk_irq_gate: assert property (!io_wr_b |-> !cpu_irq_enable)
        else $error("interrupts on during write");
    chk_apb_ready: assert property (psel && penable |-> pready)
        else $error("no zero-wait answer");
    chk_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
endmodule : irq_init_host_checker

//--- test/irq_init_host_tb.sv
/* Self-checking bench: APB tasks program the sequencer, the device model
   records port writes. Assumes checker and model are compiled first. */
`timescale 1ns/1ps
module irq_init_host_tb;
    logic        clk, rst_b, psel, penable, pwrite, irq_en, err;
    logic [7:0]  paddr, io_addr, io_dout, io_din;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, io_wr_b, io_rd_b, io_doe;
    int          error_cnt, cmp_count;
    irq_init_host irq_init_host_i (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .io_addr, .io_wr_b, .io_rd_b, .io_dout,
        .io_doe, .io_din, .cpu_irq_enable(irq_en));
    irq_unit_model irq_unit_model_i (.clk, .rst_b, .io_addr, .io_wr_b, .io_rd_b,
        .io_dout, .io_doe, .io_din);
    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog.
    initial begin clk = 0; forever #12.5 clk = ~clk; end
    initial begin repeat (20000) @(posedge clk); error_cnt++; summarize(); end
    // Compares one value with its expectation.
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // One APB transfer; read data and error land in q and err.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer.
        do begin @(posedge clk); end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Polls status until idle with initialisation done.
    task automatic wait_idle();
        for (int k = 0; k < 100; k++) begin
            apb(1'b0, 8'h0C, 32'h0);
            if (q[1:0] === 2'b10) break;
        end
    endtask : wait_idle
    // Runs one initialisation and checks every word the device saw.
    task automatic run(input logic [31:0] ctl, cfg, cas, input logic [7:0] f, v, c, o,
                       input logic [2:0] n);
        apb(1'b1, 8'h04, cfg);
        apb(1'b1, 8'h08, cas);
        apb(1'b1, 8'h00, ctl);
        apb(1'b1, 8'h04, 32'hFF);
        wait_idle();
        chk(q, {29'h0, ctl[1], 2'b10});
        chk(irq_en, 1'b1);
        chk(irq_unit_model_i.first_w, f);
        chk(irq_unit_model_i.vec_w, v);
        chk(irq_unit_model_i.vec_line7, {v[7:3], 3'h7});
        if (n == 3'd3) chk(irq_unit_model_i.casc_w, c);
        chk(irq_unit_model_i.opt_w, o);
        chk(irq_unit_model_i.wcnt, n);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, cfg);
    endtask : run
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; rst_b = 0;
        error_cnt = 0; cmp_count = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, 8'h04, 32'h0); chk(q, 32'h0);
        apb(1'b0, 8'h0C, 32'h0); chk(q, 32'h0);
        apb(1'b1, 8'h10, 32'h155);
        apb(1'b0, 8'h40, 32'h0); chk({q[30:0], err}, 32'h1);
        chk(irq_unit_model_i.mask_w, 8'h00);
        chk(irq_en, 1'b0);
        $display("test reset done");
        run(32'h1, 32'hA7, 32'h0, 8'h1B, 8'hA0, 8'h00, 8'h0F, 3'd2);
        $display("test single done");
        run(32'h1, 32'h08, 32'h01, 8'h11, 8'h08, 8'h01, 8'h1D, 3'd3);
        $display("test master done");
        run(32'h3, 32'h15, 32'h05, 8'h11, 8'h10, 8'h05, 8'h0B, 3'd3);
        $display("test slave done");
        apb(1'b1, 8'h10, 32'h1F0); wait_idle();
        chk(irq_unit_model_i.mask_w, 8'hF0);
        apb(1'b1, 8'h10, 32'h300); wait_idle();
        apb(1'b0, 8'h14, 32'h0); chk(q, 32'hF0);
        apb(1'b1, 8'h10, 32'h200); wait_idle();
        apb(1'b0, 8'h14, 32'h0); chk(q, 32'h10);
        $display("test operation done");
        summarize();
    end
endmodule : irq_init_host_tb
bind irq_init_host irq_init_host_checker irq_init_host_checker_i (.clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .io_addr, .io_wr_b,
    .io_rd_b, .io_dout, .io_doe, .io_din, .cpu_irq_enable);

//--- test/irq_unit_model.sv
/* Behavioural model of the interrupt unit on the device bus.
   Assumes strobes and data change on the rising edge of clk. */
`timescale 1ns/1ps
module irq_unit_model (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Device bus.
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr_b,
    input  wire logic       io_rd_b,
    input  wire logic [7:0] io_dout,
    input  wire logic       io_doe,
    output logic [7:0]      io_din
);
    logic [7:0] first_w, vec_w, casc_w, opt_w, mask_w, last_w;
    logic [1:0] step;
    logic [2:0] wcnt;
    logic       wr_q;
    // Vector for line 7 and decoded option fields.
    wire [7:0] vec_line7 = {vec_w[7:3], 3'h7};
    wire [3:0] mode = {opt_w[4], opt_w[3] & opt_w[2], opt_w[3], opt_w[1]};
    // Idle read data toggles so a stale byte is never mistaken for an answer.
    assign io_din = io_rd_b ? ~last_w : (io_addr == 8'hC6 ? mask_w : vec_w);
    ////////////////////////////////////////////////////////////////////////////
    // Captures each first word on C0 and each write to C2, and steps through the initialisation words.
    always @(posedge clk) begin
        wr_q <= io_wr_b;
        last_w <= io_din;
        if (!rst_b) begin
            step <= 2'h0;
            wcnt <= 3'h0;
            mask_w <= 8'h00;
        end else if (wr_q && !io_wr_b && io_doe) begin
            if (io_addr == 8'hC0 && io_dout[4]) begin
                first_w <= io_dout;
                step <= 2'h1;
                wcnt <= 3'h0;
            end else if (io_addr == 8'hC2) begin
                wcnt <= wcnt + 3'h1;
                case (step)
                    2'h1: begin vec_w <= io_dout; step <= first_w[1] ? 2'h3 : 2'h2; end
                    2'h2: begin casc_w <= io_dout; step <= 2'h3; end
                    2'h3: begin opt_w <= io_dout; step <= 2'h0; end
                    default: mask_w <= io_dout;
                endcase
            end
        end
    end
endmodule : irq_unit_model
